// ==== monitor_interrupt_and_io_logic.sv ====
// Purpose: Alert, io pin, overheat pin and rail reset logic of a monitor.
// Assumes: Measurement engines and register port share i_clk.
// Notes:   Pins other than the standby rail reset are open drain; o_*_oe high pulls the pin low.
// Behaviour
// - Shared fan pins become io pins when their select bit is set.
// - Pin sixteen is io when its select bit is one, else overheat pin.
// - Direction one means output; polarity one means active high.
// - Input pin status is read-only and shows the asserted input.
// - Output pin status is writable and drives the asserted level.
// - Mask bits hide io status; outputs auto-masked except pin sixteen.
// - Result out of limit when above high or at or below low.
// - Masked analog status ORed sets a latch feeding the alert.
// - Cleared analog latch stays off for two local temperature results.
// - Fan start or stop under auto control flags once, clears at monitor cycle end or status read.
// - Overheat change flags status and the offending channel bit.
// - Masked fan status latches; once cleared waits a fan cycle.
// - Io inputs are unlatched alert sources; intrusion holds until its clear bit.
// - Alert enabled only with enable bit high and clear bit low.
// - Status read, alert response or clear bit clear every alert source but io and intrusion.
// - Exceeded limit drives overheat pin low and forces cooling.
// - Overheat status sets even with the overheat output disabled.
// - Overheat releases only when all temperatures are 5 below limit.
// - Overheat raises the alert once per change of state.
// - External low on the overheat pin forces cooling full scale.
// - Rail resets release 180 ms after their supply, main after standby.
// - Main reset pin pulled low reloads register defaults.
`timescale 1ns/10ps
module monitor_interrupt_and_io_logic #(
  parameter int unsigned RST_CYCLES = monitor_pkg::RST_STRETCH_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic [16:0]           i_io_pin,
  output logic      [16:0]           o_io_out,
  output logic      [16:0]           o_io_oe,
  input  wire monitor_pkg::meas_t    i_meas,
  input  wire monitor_pkg::fan_meas_t i_fan,
  input  wire monitor_pkg::temps_t   i_temps,
  input  wire logic [15:0]           i_analog_mask,
  input  wire logic [7:0]            i_fan_mask,
  input  wire logic                  i_local_temp_done,
  input  wire logic                  i_monitor_cycle_end,
  input  wire logic                  i_fan_cycle_end,
  input  wire logic                  i_fan_start_stop,
  input  wire logic                  i_status1_read,
  input  wire logic                  i_alert_response,
  input  wire logic                  i_intrusion_in,
  input  wire logic                  i_main_good,
  input  wire logic                  i_stby_good,
  input  wire logic                  i_main_rail_reset_n,
  output logic                       o_main_rail_reset_n_out,
  output logic                       o_main_rail_reset_n_oe,
  output logic                       o_standby_rail_reset_n,
  output logic                       o_alert_n_out,
  output logic                       o_alert_n_oe,
  output logic                       o_cooling_full,
  output logic [16:0]                o_analog_status,
  output logic [7:0]                 o_fan_status,
  output logic [7:0]                 o_tach_select
);

  logic [7:0]  main_cfg_reg;
  logic [7:0]  pin_func_reg;
  logic [7:0]  aux_reg;
  logic [7:0]  io_cfg_reg [4];
  logic [7:0]  oh_lim_reg [3];
  logic [7:0]  ev_mask4_reg;
  logic [7:0]  io_mask_a_reg;
  logic [7:0]  io_mask_b_reg;
  logic [20:0] sync1_reg;
  logic [20:0] sync2_reg;
  logic [16:0] pin_sync;
  logic [16:0] io_dir;
  logic [16:0] io_pol;
  logic [16:0] io_gpio;
  logic [16:0] io_st;
  logic [16:0] io_wen;
  logic [16:0] io_wval;
  logic [16:0] auto_mask;
  logic [16:0] an_st_reg;
  logic [7:0]  fan_st_reg;
  logic [1:0]  an_block_reg;
  logic        fan_block_reg;
  logic        an_latch_reg;
  logic        fan_latch_reg;
  logic        oh_reg;
  logic        oh_prev_reg;
  logic        ev_oh_reg;
  logic        ev_afc_reg;
  logic        ev_ci_reg;
  logic        afc_alert_reg;
  logic        overheat_pin_alert_reg;
  logic        soft_rst;
  logic        clear_evt;
  logic        oh_change;
  logic        oh_drive;
  logic        afc_evt;
  logic        io_src;
  logic        ci_src;
  logic        alert_active;
  logic        stby_rel;
  logic        main_rel;
  logic [2:0]  exc;
  logic [2:0]  below;
  logic [7:0]  ev_stat4;
  logic [7:0]  temp_v [3];

  function automatic logic io_level(input logic pol, input logic v);
    io_level = pol ? v : ~v;
  endfunction

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_main_rail_reset_n, i_intrusion_in, i_stby_good,
                    i_main_good, i_io_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_sync = sync2_reg[16:0];
  assign soft_rst = main_cfg_reg[monitor_pkg::MCFG_SOFT_RST]
                  | ~sync2_reg[20];
  assign clear_evt = i_status1_read | i_alert_response
                   | main_cfg_reg[monitor_pkg::MCFG_ALERT_CLR];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      main_cfg_reg  <= monitor_pkg::REG_RESET;
      pin_func_reg  <= monitor_pkg::REG_RESET;
      aux_reg       <= monitor_pkg::REG_RESET;
      io_cfg_reg    <= '{default: monitor_pkg::REG_RESET};
      oh_lim_reg    <= '{default: monitor_pkg::OH_LIM_RESET};
      ev_mask4_reg  <= monitor_pkg::REG_RESET;
      io_mask_a_reg <= monitor_pkg::REG_RESET;
      io_mask_b_reg <= monitor_pkg::REG_RESET;
    end else if (soft_rst) begin
      main_cfg_reg  <= monitor_pkg::REG_RESET;
      pin_func_reg  <= monitor_pkg::REG_RESET;
      aux_reg       <= monitor_pkg::REG_RESET;
      io_cfg_reg    <= '{default: monitor_pkg::REG_RESET};
      oh_lim_reg    <= '{default: monitor_pkg::OH_LIM_RESET};
      ev_mask4_reg  <= monitor_pkg::REG_RESET;
      io_mask_a_reg <= monitor_pkg::REG_RESET;
      io_mask_b_reg <= monitor_pkg::REG_RESET;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        monitor_pkg::ADDR_MAIN_CFG:  main_cfg_reg  <= i_reg_wdata;
        monitor_pkg::ADDR_PIN_FUNC:  pin_func_reg  <= i_reg_wdata;
        monitor_pkg::ADDR_AUX_CFG:   aux_reg       <= i_reg_wdata;
        monitor_pkg::ADDR_IO_CFG_A:  io_cfg_reg[0] <= i_reg_wdata;
        monitor_pkg::ADDR_IO_CFG_B:  io_cfg_reg[1] <= i_reg_wdata;
        monitor_pkg::ADDR_IO_CFG_C:  io_cfg_reg[2] <= i_reg_wdata;
        monitor_pkg::ADDR_IO_CFG_D:  io_cfg_reg[3] <= i_reg_wdata;
        monitor_pkg::ADDR_OH_LIM_A:  oh_lim_reg[0] <= i_reg_wdata;
        monitor_pkg::ADDR_OH_LIM_B:  oh_lim_reg[1] <= i_reg_wdata;
        monitor_pkg::ADDR_OH_LIM_C:  oh_lim_reg[2] <= i_reg_wdata;
        monitor_pkg::ADDR_EV_MASK4:  ev_mask4_reg  <= i_reg_wdata;
        monitor_pkg::ADDR_IO_MASK_A: io_mask_a_reg <= i_reg_wdata;
        monitor_pkg::ADDR_IO_MASK_B: io_mask_b_reg <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  assign io_wen[7:0]  = {8{i_reg_wr && i_reg_addr == monitor_pkg::ADDR_IO_STAT_A}};
  assign io_wen[15:8] = {8{i_reg_wr && i_reg_addr == monitor_pkg::ADDR_IO_STAT_B}};
  assign io_wen[16]   = i_reg_wr && i_reg_addr == monitor_pkg::ADDR_EV_STAT4;
  assign io_wval      = {i_reg_wdata[monitor_pkg::EV_IO16], i_reg_wdata,
                         i_reg_wdata};

  for (genvar i = 0; i < 17; i++) begin : g_pin
    logic st_reg;
    if (i < 8) begin : g_shared
      assign io_gpio[i]   = pin_func_reg[i];
      assign io_dir[i]    = io_cfg_reg[i/4][2*(i%4)];
      assign io_pol[i]    = io_cfg_reg[i/4][2*(i%4)+1];
      assign auto_mask[i] = io_dir[i];
    end else if (i < 16) begin : g_fixed
      assign io_gpio[i]   = 1'b1;
      assign io_dir[i]    = io_cfg_reg[i/4][2*(i%4)];
      assign io_pol[i]    = io_cfg_reg[i/4][2*(i%4)+1];
      assign auto_mask[i] = io_dir[i];
    end else begin : g_sixteen
      assign io_gpio[i]   = aux_reg[monitor_pkg::AUX_IO16_SEL];
      assign io_dir[i]    = aux_reg[monitor_pkg::AUX_IO16_DIR];
      assign io_pol[i]    = aux_reg[monitor_pkg::AUX_IO16_POL];
      assign auto_mask[i] = 1'b0;
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        st_reg <= 1'b0;
      end else if (soft_rst || !io_gpio[i]) begin
        st_reg <= 1'b0;
      end else if (!io_dir[i]) begin
        st_reg <= io_level(io_pol[i], pin_sync[i]);
      end else if (io_wen[i]) begin
        st_reg <= io_wval[i];
      end
    end
    assign io_st[i] = st_reg;
    if (i < 16) begin : g_drv
      assign o_io_oe[i] = io_gpio[i] & io_dir[i]
                        & ~io_level(io_pol[i], st_reg);
    end else begin : g_drv16
      assign o_io_oe[i] = io_gpio[i]
                        ? io_dir[i] & ~io_level(io_pol[i], st_reg)
                        : oh_drive;
    end
  end

  assign o_io_out = '0;
  assign o_tach_select = ~pin_func_reg;

  assign io_src = |(io_st & ~auto_mask
                    & ~{ev_mask4_reg[monitor_pkg::EV_IO16], io_mask_b_reg,
                        io_mask_a_reg});
  assign ci_src = ev_ci_reg & ~ev_mask4_reg[monitor_pkg::EV_CI];

  assign temp_v[0] = i_temps.a;
  assign temp_v[1] = i_temps.b;
  assign temp_v[2] = i_temps.c;
  for (genvar t = 0; t < 3; t++) begin : g_temp
    assign exc[t]   = temp_v[t] > oh_lim_reg[t];
    assign below[t] = ({1'b0, temp_v[t]} + monitor_pkg::OH_HYST)
                    <= {1'b0, oh_lim_reg[t]};
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oh_reg      <= 1'b0;
      oh_prev_reg <= 1'b0;
    end else begin
      oh_prev_reg <= oh_reg;
      if (|exc) begin
        oh_reg <= 1'b1;
      end else if (&below) begin
        oh_reg <= 1'b0;
      end
    end
  end

  assign oh_change = oh_reg ^ oh_prev_reg;
  assign oh_drive  = oh_reg & main_cfg_reg[monitor_pkg::MCFG_OH_EN]
                   & ~aux_reg[monitor_pkg::AUX_IO16_SEL];
  assign o_cooling_full = (oh_reg & main_cfg_reg[monitor_pkg::MCFG_OH_EN])
                        | (~aux_reg[monitor_pkg::AUX_IO16_SEL]
                           & ~pin_sync[16] & ~oh_drive);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      an_st_reg <= '0;
    end else if (soft_rst) begin
      an_st_reg <= '0;
    end else begin
      if (i_meas.valid && i_meas.index < 5'(monitor_pkg::N_ANALOG)) begin
        an_st_reg[i_meas.index] <= (i_meas.value > i_meas.high)
                                 | (i_meas.value <= i_meas.low);
      end
      if (oh_change && exc[0]) an_st_reg[monitor_pkg::TEMP_IDX_A] <= 1'b1;
      if (oh_change && exc[1]) an_st_reg[monitor_pkg::TEMP_IDX_B] <= 1'b1;
      if (oh_change && exc[2]) an_st_reg[monitor_pkg::TEMP_IDX_C] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      an_latch_reg <= 1'b0;
      an_block_reg <= '0;
    end else if (clear_evt) begin
      an_latch_reg <= 1'b0;
      an_block_reg <= monitor_pkg::LOCAL_T_WAIT;
    end else if (an_block_reg != 2'h0) begin
      if (i_local_temp_done) an_block_reg <= an_block_reg - 2'h1;
    end else if (|(an_st_reg & ~{ev_mask4_reg[monitor_pkg::EV_TEMP],
                                   i_analog_mask})) begin
      an_latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fan_st_reg <= '0;
    end else if (soft_rst) begin
      fan_st_reg <= '0;
    end else if (i_fan.valid) begin
      fan_st_reg[i_fan.index] <= i_fan.count > i_fan.limit;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fan_latch_reg <= 1'b0;
      fan_block_reg <= 1'b0;
    end else if (clear_evt) begin
      fan_latch_reg <= 1'b0;
      fan_block_reg <= 1'b1;
    end else if (fan_block_reg) begin
      fan_block_reg <= ~i_fan_cycle_end;
    end else if (|(fan_st_reg & ~i_fan_mask)) begin
      fan_latch_reg <= 1'b1;
    end
  end

  assign afc_evt = i_fan_start_stop
                 & (main_cfg_reg[monitor_pkg::MCFG_AFC_DAC]
                    | main_cfg_reg[monitor_pkg::MCFG_AFC_PWM]);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_afc_reg    <= 1'b0;
      afc_alert_reg <= 1'b0;
    end else begin
      if (afc_evt) begin
        ev_afc_reg <= 1'b1;
      end else if (i_monitor_cycle_end || i_status1_read) begin
        ev_afc_reg <= 1'b0;
      end
      if (afc_evt) begin
        afc_alert_reg <= 1'b1;
      end else if (clear_evt) begin
        afc_alert_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_oh_reg       <= 1'b0;
      overheat_pin_alert_reg <= 1'b0;
    end else begin
      if (oh_change || (|exc)) begin
        ev_oh_reg <= 1'b1;
      end else if (i_status1_read) begin
        ev_oh_reg <= 1'b0;
      end
      if (oh_change) begin
        overheat_pin_alert_reg <= 1'b1;
      end else if (clear_evt) begin
        overheat_pin_alert_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_ci_reg <= 1'b0;
    end else if (sync2_reg[19]) begin
      ev_ci_reg <= 1'b1;
    end else if (aux_reg[monitor_pkg::AUX_CI_CLR]) begin
      ev_ci_reg <= 1'b0;
    end
  end

  assign alert_active = an_latch_reg | fan_latch_reg | afc_alert_reg
                      | overheat_pin_alert_reg | io_src | ci_src;
  assign o_alert_n_out = 1'b0;
  assign o_alert_n_oe  = alert_active
                       & main_cfg_reg[monitor_pkg::MCFG_ALERT_EN]
                       & ~main_cfg_reg[monitor_pkg::MCFG_ALERT_CLR];

  assign ev_stat4 = {io_st[16], ev_ci_reg, 1'b0, ev_afc_reg, ev_oh_reg,
                     2'b00, an_st_reg[16]};
  assign o_analog_status = an_st_reg;
  assign o_fan_status    = fan_st_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        monitor_pkg::ADDR_MAIN_CFG:  o_reg_rdata <= main_cfg_reg;
        monitor_pkg::ADDR_PIN_FUNC:  o_reg_rdata <= pin_func_reg;
        monitor_pkg::ADDR_AUX_CFG:   o_reg_rdata <= aux_reg;
        monitor_pkg::ADDR_IO_CFG_A:  o_reg_rdata <= io_cfg_reg[0];
        monitor_pkg::ADDR_IO_CFG_B:  o_reg_rdata <= io_cfg_reg[1];
        monitor_pkg::ADDR_IO_CFG_C:  o_reg_rdata <= io_cfg_reg[2];
        monitor_pkg::ADDR_IO_CFG_D:  o_reg_rdata <= io_cfg_reg[3];
        monitor_pkg::ADDR_OH_LIM_A:  o_reg_rdata <= oh_lim_reg[0];
        monitor_pkg::ADDR_OH_LIM_B:  o_reg_rdata <= oh_lim_reg[1];
        monitor_pkg::ADDR_OH_LIM_C:  o_reg_rdata <= oh_lim_reg[2];
        monitor_pkg::ADDR_EV_MASK4:  o_reg_rdata <= ev_mask4_reg;
        monitor_pkg::ADDR_IO_MASK_A: o_reg_rdata <= io_mask_a_reg;
        monitor_pkg::ADDR_IO_MASK_B: o_reg_rdata <= io_mask_b_reg;
        monitor_pkg::ADDR_EV_STAT4:  o_reg_rdata <= ev_stat4;
        monitor_pkg::ADDR_IO_STAT_A: o_reg_rdata <= io_st[7:0];
        monitor_pkg::ADDR_IO_STAT_B: o_reg_rdata <= io_st[15:8];
        default:                     o_reg_rdata <= '0;
      endcase
    end
  end

  rail_stretch_timer #(.CYCLES(RST_CYCLES)) u_stby_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (sync2_reg[18]),
    .o_release (stby_rel)
  );

  rail_stretch_timer #(.CYCLES(RST_CYCLES)) u_main_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (sync2_reg[17] & stby_rel),
    .o_release (main_rel)
  );

  assign o_standby_rail_reset_n  = stby_rel;
  assign o_main_rail_reset_n_out = 1'b0;
  assign o_main_rail_reset_n_oe  = ~(main_rel & stby_rel);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  alert_gate_a: assert property (
    o_alert_n_oe |-> main_cfg_reg[1] && !main_cfg_reg[2])
    else $error("alert driven while disabled");
  limit_cmp_a: assert property (
    i_meas.valid && i_meas.index == 5'h03 && !soft_rst
    && i_meas.value <= i_meas.low |=> an_st_reg[3])
    else $error("low limit miss");
  fan_mode_a: assert property (
    !pin_func_reg[2] && $past(!pin_func_reg[2]) |-> !io_st[2] && !o_io_oe[2])
    else $error("fan pin acts as io");
  analog_hold_a: assert property (
    clear_evt |=> !an_latch_reg && an_block_reg != 2'h0)
    else $error("analog latch not held off");
  oh_hyst_a: assert property (
    oh_reg && !(&below) |=> oh_reg)
    else $error("overheat released early");
  oh_drive_a: assert property (
    oh_reg && main_cfg_reg[4] && !aux_reg[0] |-> o_io_oe[16] && o_cooling_full)
    else $error("overheat not driven");
  oh_status_a: assert property (
    (|exc) |=> ev_oh_reg)
    else $error("overheat status missed");
  overheat_pin_edge_a: assert property (
    oh_change |=> overheat_pin_alert_reg ##1 (overheat_pin_alert_reg || $past(clear_evt)))
    else $error("overheat edge lost");
  alert_clear_a: assert property (
    i_status1_read && !oh_change && !afc_evt
    |=> !overheat_pin_alert_reg && !afc_alert_reg && !an_latch_reg && !fan_latch_reg)
    else $error("alert not cleared");
  rail_order_a: assert property (
    !stby_rel |-> o_main_rail_reset_n_oe)
    else $error("main released before standby");
  io16_cool_a: assert property (
    aux_reg[0] && !(oh_reg && main_cfg_reg[4]) |-> !o_cooling_full)
    else $error("io sixteen forces cooling");

  oh_seen_c: cover property (oh_change && main_cfg_reg[4]);
  clear_c: cover property (clear_evt && an_latch_reg);
  alert_c: cover property (o_alert_n_oe && fan_latch_reg);
endmodule

// ==== monitor_pkg.sv ====
// Purpose: Shared constants and carrier types for the monitor alert logic.
// Assumes: One 50 MHz clock; registers are 8 bits wide.
// Notes:   Offsets are byte addresses of the management register port.
package monitor_pkg;

  localparam logic [7:0] ADDR_MAIN_CFG  = 8'h00;
  localparam logic [7:0] ADDR_PIN_FUNC  = 8'h01;
  localparam logic [7:0] ADDR_AUX_CFG   = 8'h07;
  localparam logic [7:0] ADDR_IO_CFG_A  = 8'h08;
  localparam logic [7:0] ADDR_IO_CFG_B  = 8'h09;
  localparam logic [7:0] ADDR_IO_CFG_C  = 8'h0a;
  localparam logic [7:0] ADDR_IO_CFG_D  = 8'h0b;
  localparam logic [7:0] ADDR_OH_LIM_A  = 8'h0d;
  localparam logic [7:0] ADDR_OH_LIM_B  = 8'h0e;
  localparam logic [7:0] ADDR_OH_LIM_C  = 8'h0f;
  localparam logic [7:0] ADDR_EV_MASK4  = 8'h1b;
  localparam logic [7:0] ADDR_IO_MASK_A = 8'h1c;
  localparam logic [7:0] ADDR_IO_MASK_B = 8'h1d;
  localparam logic [7:0] ADDR_EV_STAT4  = 8'h23;
  localparam logic [7:0] ADDR_IO_STAT_A = 8'h24;
  localparam logic [7:0] ADDR_IO_STAT_B = 8'h25;

  localparam int MCFG_ALERT_EN  = 1;
  localparam int MCFG_ALERT_CLR = 2;
  localparam int MCFG_OH_EN     = 4;
  localparam int MCFG_AFC_DAC   = 5;
  localparam int MCFG_AFC_PWM   = 6;
  localparam int MCFG_SOFT_RST  = 7;
  localparam int AUX_IO16_SEL   = 0;
  localparam int AUX_CI_CLR     = 1;
  localparam int AUX_IO16_DIR   = 6;
  localparam int AUX_IO16_POL   = 7;
  localparam int EV_TEMP        = 0;
  localparam int EV_OH          = 3;
  localparam int EV_AFC         = 4;
  localparam int EV_CI          = 6;
  localparam int EV_IO16        = 7;

  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] OH_LIM_RESET  = 8'h7f;
  localparam logic [8:0] OH_HYST       = 9'h005;
  localparam logic [1:0] LOCAL_T_WAIT  = 2'h2;
  localparam int         N_ANALOG      = 17;
  localparam logic [4:0] TEMP_IDX_A    = 5'h00;
  localparam logic [4:0] TEMP_IDX_B    = 5'h01;
  localparam logic [4:0] TEMP_IDX_C    = 5'h10;

  localparam int CLK_MHZ         = 50;
  localparam int RST_STRETCH_MS  = 180;
  localparam int RST_STRETCH_CYC = RST_STRETCH_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic       valid;
    logic [4:0] index;
    logic [7:0] value;
    logic [7:0] high;
    logic [7:0] low;
  } meas_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] index;
    logic [7:0] count;
    logic [7:0] limit;
  } fan_meas_t;

  typedef struct packed {
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } temps_t;

endpackage

// ==== rail_stretch_timer.sv ====
// Purpose: Holds a reset release back until its enable has stood long enough.
// Assumes: Enable is synchronous to i_clk.
// Notes:   Dropping the enable restarts the count and reasserts reset.
`timescale 1ns/10ps
module rail_stretch_timer #(
  parameter int unsigned CYCLES = monitor_pkg::RST_STRETCH_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_enable,
  output logic      o_release
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_reg <= '0;
      o_release <= 1'b0;
    end else if (!i_enable) begin
      count_reg <= '0;
      o_release <= 1'b0;
    end else if (!o_release) begin
      count_reg <= count_reg + 1'b1;
      o_release <= (count_reg == LAST);
    end
  end
endmodule

// ==== host_port_model.sv ====
// Purpose: Management host model that drives the register port.
// Assumes: Requests change at the falling edge of i_clk.
// Notes:   Each access is one strobe cycle; write data is inverted after a write.
`timescale 1ns/10ps
module host_port_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    {o_wr, o_rd} = 2'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// ==== monitor_interrupt_and_io_logic_tb_top.sv ====
// Purpose: Self-checking bench for the monitor alert and io logic.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Rail stretch is shortened to 16 cycles.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  error_cnt++; $display("MISMATCH %0t got %h", $time, a); end end
module monitor_interrupt_and_io_logic_tb_top;
  logic i_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_local_temp_done;
  logic i_monitor_cycle_end, i_fan_cycle_end, i_fan_start_stop;
  logic i_status1_read, i_alert_response, i_intrusion_in, i_main_good;
  logic i_stby_good, o_main_rail_reset_n_out, o_main_rail_reset_n_oe;
  logic o_standby_rail_reset_n, o_alert_n_out, o_alert_n_oe, o_cooling_full;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_fan_mask;
  logic [7:0]  o_fan_status, o_tach_select, rd_val;
  logic [15:0] i_analog_mask;
  logic [16:0] i_io_pin, o_io_out, o_io_oe, o_analog_status, pin_drv;
  monitor_pkg::meas_t     i_meas;
  monitor_pkg::fan_meas_t i_fan;
  monitor_pkg::temps_t    i_temps;
  wire i_main_rail_reset_n = ~o_main_rail_reset_n_oe;
  int error_cnt = 0;
  int check_count = 0;
  assign i_io_pin = pin_drv & ~o_io_oe;
  monitor_interrupt_and_io_logic #(.RST_CYCLES(16)) uut (
    .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .i_io_pin, .o_io_out, .o_io_oe, .i_meas, .i_fan, .i_temps,
    .i_analog_mask, .i_fan_mask, .i_local_temp_done, .i_monitor_cycle_end,
    .i_fan_cycle_end, .i_fan_start_stop, .i_status1_read, .i_alert_response,
    .i_intrusion_in, .i_main_good, .i_stby_good, .i_main_rail_reset_n,
    .o_main_rail_reset_n_out, .o_main_rail_reset_n_oe,
    .o_standby_rail_reset_n, .o_alert_n_out, .o_alert_n_oe, .o_cooling_full,
    .o_analog_status, .o_fan_status, .o_tach_select);
  host_port_model host (.i_clk, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic t_rails;
    int n = 0;
    while (o_main_rail_reset_n_oe !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    `CHK({o_standby_rail_reset_n, o_main_rail_reset_n_out}, 2'h2)
    `CHK(n >= 32 && n < 200, 1'b1)
    if (n >= 200) complete_run;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic t_cfg;
    `CHK(o_tach_select, 8'hff)
    host.wr(8'h00, 8'h12);
    host.wr(8'h01, 8'h0f);
    host.rd(8'h00, rd_val);
    `CHK({rd_val, o_tach_select}, 16'h12f0)
    host.rd(8'h30, rd_val);
    `CHK(rd_val, 8'h00)
  endtask
  task automatic t_analog;
    @(negedge i_clk);
    i_meas = {1'h1, 5'h03, 8'h10, 8'h80, 8'h10};
    @(negedge i_clk);
    i_meas.valid = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK(o_analog_status[3], 1'b1)
    `CHK({o_alert_n_oe, o_alert_n_out}, 2'h2)
    pulse(i_status1_read);
    `CHK({o_alert_n_oe, o_analog_status[3]}, 2'h1)
    pulse(i_local_temp_done);
    repeat (2) @(negedge i_clk);
    `CHK(o_alert_n_oe, 1'b0)
    pulse(i_local_temp_done);
    repeat (2) @(negedge i_clk);
    `CHK(o_alert_n_oe, 1'b1)
    i_analog_mask[3] = 1'b1;
    pulse(i_alert_response);
    `CHK(o_alert_n_oe, 1'b0)
  endtask
  task automatic t_io;
    host.wr(8'h0a, 8'h01);
    host.wr(8'h25, 8'h01);
    repeat (2) @(negedge i_clk);
    `CHK({o_io_oe[9:8], o_alert_n_oe}, 3'h2)
    host.wr(8'h0a, 8'h09);
    repeat (4) @(negedge i_clk);
    host.rd(8'h25, rd_val);
    `CHK({rd_val, o_alert_n_oe}, 9'h007)
    host.wr(8'h1d, 8'h02);
    @(negedge i_clk);
    `CHK(o_alert_n_oe, 1'b0)
  endtask
  task automatic t_oh;
    i_temps.a = 8'h80;
    repeat (3) @(negedge i_clk);
    `CHK({o_io_oe[16], o_cooling_full, o_alert_n_oe}, 3'h7)
    host.rd(8'h23, rd_val);
    `CHK(rd_val[3], 1'b1)
    pulse(i_status1_read);
    i_temps.a = 8'h7b;
    repeat (3) @(negedge i_clk);
    `CHK({o_io_oe[16], o_alert_n_oe}, 2'h2)
    i_temps.a = 8'h7a;
    repeat (5) @(negedge i_clk);
    `CHK({o_io_oe[16], o_cooling_full}, 2'h0)
    pin_drv[16] = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK(o_cooling_full, 1'b1)
    pin_drv[16] = 1'b1;
  endtask
  task automatic t_fan;
    pulse(i_alert_response);
    i_fan = {1'h1, 3'h2, 8'hf0, 8'h80};
    @(negedge i_clk);
    i_fan.valid = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK({o_fan_status, o_alert_n_oe}, 9'h008)
    pulse(i_fan_cycle_end);
    `CHK(o_alert_n_oe, 1'b1)
    pulse(i_status1_read);
    `CHK(o_alert_n_oe, 1'b0)
    host.wr(8'h00, 8'h32);
    pulse(i_fan_start_stop);
    host.rd(8'h23, rd_val);
    `CHK({rd_val, o_alert_n_oe}, 9'h021)
    pulse(i_monitor_cycle_end);
    host.rd(8'h23, rd_val);
    `CHK({rd_val, o_alert_n_oe}, 9'h001)
    pulse(i_alert_response);
    i_intrusion_in = 1'b1;
    repeat (4) @(negedge i_clk);
    pulse(i_status1_read);
    host.rd(8'h23, rd_val);
    `CHK({rd_val, o_alert_n_oe}, 9'h081)
    i_intrusion_in = 1'b0;
    host.wr(8'h07, 8'h02);
    repeat (2) @(negedge i_clk);
    `CHK(o_alert_n_oe, 1'b0)
  endtask
  initial begin
    i_sys_rst = 1'b1;
    {i_local_temp_done, i_monitor_cycle_end, i_fan_cycle_end} = 3'h0;
    {i_fan_start_stop, i_status1_read, i_alert_response} = 3'h0;
    {i_intrusion_in, i_main_good, i_stby_good} = 3'h3;
    {i_meas, i_fan, i_temps, i_fan_mask, i_analog_mask} = '0;
    pin_drv = 17'h1ffff;
    repeat (16) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_rails;
    t_cfg;
    t_analog;
    t_io;
    t_oh;
    t_fan;
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    complete_run;
  end
endmodule
